/* File: design/fwp_key_seq.sv */
`timescale 1ns/1ps
module fwp_key_seq
   import fwp_pkg::*;
#(
   parameter logic [31:0] KEY_FIRST = 32'h0000a5a5,
   parameter logic [31:0] KEY_SECOND = 32'h00005a5a
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   input wire logic other_wr,
   input wire logic prot_wr,
   output logic armed
);

   typedef enum logic [1:0] {KS_IDLE, KS_FIRST, KS_ARMED} fwp_ks_e;
   fwp_ks_e state_q;

   // -------------------------------------------------------------------
   // Two key words in a row arm exactly one protection register write.
   // -------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= KS_IDLE;
      end else if (key_wr) begin
         if (state_q == KS_FIRST && key_data == KEY_SECOND) begin
            state_q <= KS_ARMED;
         end else if (key_data == KEY_FIRST) begin
            state_q <= KS_FIRST;
         end else begin
            state_q <= KS_IDLE;
         end
      end else if (prot_wr || other_wr) begin
         state_q <= KS_IDLE;
      end
   end

   assign armed = (state_q == KS_ARMED);

endmodule

/* File: design/fwp_pkg.sv */
package fwp_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0] FWP_OFS_PROG = 8'h00;
   localparam logic [7:0] FWP_OFS_BOOT = 8'h04;
   localparam logic [7:0] FWP_OFS_KEY = 8'h08;
   localparam logic [7:0] FWP_OFS_STAT = 8'h0c;

   // -------------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------------
   localparam int FWP_PROG_ULOCK_BIT = 31;
   localparam int FWP_BOUND_W = 24;
   localparam int FWP_BOOT_ULOCK_BIT = 15;
   localparam int FWP_BOOT_P0_BIT = 8;
   localparam int FWP_BOOT_PAGES = 3;
   localparam logic FWP_ULOCK_RST = 1'b1;
   localparam logic [23:0] FWP_BOUND_RST = 24'h000000;
   localparam logic [2:0] FWP_BOOTP_RST = 3'h7;

   // -------------------------------------------------------------------
   // Address geometry: 2 KiB pages, page number is addr[31:11]
   // -------------------------------------------------------------------
   localparam int FWP_PAGE_LSB = 11;
   localparam logic [7:0] FWP_PROG_PREFIX = 8'h1d;
   localparam logic [20:0] FWP_BOOT_PAGE2 = 21'h03f800;
   localparam logic [20:0] FWP_BOOT_PAGE1 = 21'h03f801;
   localparam logic [20:0] FWP_BOOT_PAGE0 = 21'h03f802;

   // -------------------------------------------------------------------
   // Flash operation kinds and AXI responses
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      FWP_OP_PAGE_ERASE,
      FWP_OP_ROW_PROG,
      FWP_OP_DWORD_PROG,
      FWP_OP_NONE
   } fwp_op_e;
   localparam logic [1:0] FWP_RESP_OKAY = 2'h0;
   localparam logic [1:0] FWP_RESP_SLVERR = 2'h2;

endpackage

/* File: design/fwp_range_chk.sv */
`timescale 1ns/1ps
module fwp_range_chk
   import fwp_pkg::*;
(
   input wire logic [31:0] addr,
   input wire logic [23:0] boundary,
   input wire logic [2:0] boot_prot,
   output logic hit
);

   logic [20:0] page;
   logic [12:0] bound_page;
   logic prog_hit;
   logic boot_hit;

   assign page = addr[31:FWP_PAGE_LSB];
   assign bound_page = boundary[23:FWP_PAGE_LSB];

   // A nonzero boundary protects its own page and every page below it.
   assign prog_hit = (boundary != FWP_BOUND_RST)
      && (addr[31:24] == FWP_PROG_PREFIX)
      && (addr[23:FWP_PAGE_LSB] <= bound_page);

   assign boot_hit = (boot_prot[2] && page == FWP_BOOT_PAGE2)
      || (boot_prot[1] && page == FWP_BOOT_PAGE1)
      || (boot_prot[0] && page == FWP_BOOT_PAGE0);

   assign hit = prog_hit || boot_hit;

endmodule

/* File: design/fwp_top.sv */
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module fwp_top
   import fwp_pkg::*;
#(
   parameter logic [31:0] KEY_FIRST = 32'h0000a5a5,
   parameter logic [31:0] KEY_SECOND = 32'h00005a5a
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic op_valid,
   input wire logic [1:0] op_kind,
   input wire logic [31:0] op_addr,
   output logic op_done,
   output logic op_allowed,
   output logic op_refused
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic prog_ulock_q;
   logic [23:0] bound_q;
   logic boot_ulock_q;
   logic [2:0] bootp_q;
   logic [7:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic last_refused_q;
   logic [7:0] refuse_cnt_q;
   logic [31:0] wmask;
   logic do_write;
   logic wr_prog;
   logic wr_boot;
   logic wr_key;
   logic wr_stat;
   logic mapped_wr;
   logic prot_ok;
   logic armed;
   logic hit;
   logic [31:0] rd_word;

   // -------------------------------------------------------------------
   // AXI4-Lite write channels
   // -------------------------------------------------------------------
   // Address and data are caught independently and joined here.
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         if (do_write) begin
            aw_held_q <= 1'b0;
         end else if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= 1'b0;
         if (do_write) begin
            w_held_q <= 1'b0;
         end else if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   assign wr_prog = do_write && awaddr_q == FWP_OFS_PROG;
   assign wr_boot = do_write && awaddr_q == FWP_OFS_BOOT;
   assign wr_key = do_write && awaddr_q == FWP_OFS_KEY;
   assign wr_stat = do_write && awaddr_q == FWP_OFS_STAT;
   assign mapped_wr = wr_prog || wr_boot || wr_key || wr_stat;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                   {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign prot_ok = armed;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= FWP_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped_wr ? FWP_RESP_OKAY : FWP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Key sequence
   // -------------------------------------------------------------------
   fwp_key_seq #(
      .KEY_FIRST(KEY_FIRST),
      .KEY_SECOND(KEY_SECOND)
   ) u_key (
      .aclk(aclk),
      .aresetn(aresetn),
      .key_wr(wr_key),
      .key_data(wdata_q),
      .other_wr(wr_stat || (do_write && !mapped_wr)),
      .prot_wr(wr_prog || wr_boot),
      .armed(armed)
   );

   // -------------------------------------------------------------------
   // Program flash protection register
   // -------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_ulock_q <= FWP_ULOCK_RST;
      end else if (wr_prog && prot_ok && wmask[FWP_PROG_ULOCK_BIT]) begin
         // A written 1 keeps the bit, a written 0 clears it for good.
         prog_ulock_q <= prog_ulock_q
            & wdata_q[FWP_PROG_ULOCK_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bound_q <= FWP_BOUND_RST;
      end else if (wr_prog && prot_ok && prog_ulock_q) begin
         bound_q <= (bound_q & ~wmask[23:0])
            | (wdata_q[23:0] & wmask[23:0]);
      end
   end

   // -------------------------------------------------------------------
   // Boot page protection register
   // -------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_ulock_q <= FWP_ULOCK_RST;
      end else if (wr_boot && prot_ok && wmask[FWP_BOOT_ULOCK_BIT]) begin
         boot_ulock_q <= boot_ulock_q
            & wdata_q[FWP_BOOT_ULOCK_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bootp_q <= FWP_BOOTP_RST;
      end else if (wr_boot && prot_ok && boot_ulock_q
                   && wmask[FWP_BOOT_P0_BIT]) begin
         bootp_q <= wdata_q[FWP_BOOT_P0_BIT +: FWP_BOOT_PAGES];
      end
   end

   // -------------------------------------------------------------------
   // Flash operation gate
   // -------------------------------------------------------------------
   fwp_range_chk u_chk (
      .addr(op_addr),
      .boundary(bound_q),
      .boot_prot(bootp_q),
      .hit(hit)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_done <= 1'b0;
         op_allowed <= 1'b0;
         op_refused <= 1'b0;
      end else begin
         op_done <= op_valid && op_kind != FWP_OP_NONE;
         op_allowed <= op_valid && op_kind != FWP_OP_NONE && !hit;
         op_refused <= op_valid && op_kind != FWP_OP_NONE && hit;
      end
   end

   // Status keeps the last verdict and a saturating refusal count.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_refused_q <= 1'b0;
         refuse_cnt_q <= 8'h00;
      end else if (op_valid && op_kind != FWP_OP_NONE) begin
         last_refused_q <= hit;
         if (hit && refuse_cnt_q != 8'hff) begin
            refuse_cnt_q <= refuse_cnt_q + 8'h01;
         end
      end else if (wr_stat && wmask[0] && wdata_q[0]) begin
         refuse_cnt_q <= 8'h00;
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------
   always_comb begin
      rd_word = 32'h00000000;
      unique case (s_axi_araddr)
         FWP_OFS_PROG: begin
            rd_word[FWP_PROG_ULOCK_BIT] = prog_ulock_q;
            rd_word[23:0] = bound_q;
         end
         FWP_OFS_BOOT: begin
            rd_word[FWP_BOOT_ULOCK_BIT] = boot_ulock_q;
            rd_word[FWP_BOOT_P0_BIT +: FWP_BOOT_PAGES] = bootp_q;
         end
         FWP_OFS_KEY: begin
            rd_word = 32'h00000000;
         end
         FWP_OFS_STAT: begin
            rd_word[0] = last_refused_q;
            rd_word[1] = armed;
            rd_word[15:8] = refuse_cnt_q;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= FWP_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr == FWP_OFS_PROG
                            || s_axi_araddr == FWP_OFS_BOOT
                            || s_axi_araddr == FWP_OFS_KEY
                            || s_axi_araddr == FWP_OFS_STAT)
                           ? FWP_RESP_OKAY : FWP_RESP_SLVERR;
         end
      end
   end

endmodule

/* File: sim/fwp_top_chk_sva.sv */
`timescale 1ns/1ps
module fwp_top_chk
   import fwp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic op_valid,
   input wire logic [1:0] op_kind,
   input wire logic [31:0] op_addr,
   input wire logic op_done,
   input wire logic op_allowed,
   input wire logic op_refused
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] rd_ofs_q;
   logic plock_q, block_q, take, outside, rp, rb;
   assign take = op_valid && op_kind != 2'h3;
   assign outside = op_addr[31:24] != 8'h1d &&
      !(op_addr >= 32'h1fc00000 && op_addr <= 32'h1fc017ff);
   assign rp = s_axi_rvalid && rd_ofs_q == FWP_OFS_PROG;
   assign rb = s_axi_rvalid && rd_ofs_q == FWP_OFS_BOOT;
   // -------------------------------------------------------------
   // Track the read in flight and any lock seen since reset.
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ofs_q <= 8'h00;
      end else if (s_axi_arvalid) begin
         rd_ofs_q <= s_axi_araddr;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         plock_q <= 1'b0;
         block_q <= 1'b0;
      end else begin
         plock_q <= plock_q || (rp && !s_axi_rdata[31]);
         block_q <= block_q || (rb && !s_axi_rdata[15]);
      end
   end
   a_op_answer: assert property (take |=> op_done && (op_allowed ^ op_refused))
      else $error("operation check gave no single verdict");
   a_op_quiet: assert property (!take |=> !op_done && !op_allowed && !op_refused)
      else $error("verdict without a request");
   a_op_outside: assert property (take && outside |=> op_allowed)
      else $error("unprotected address refused");
   a_prog_unused: assert property (rp |-> s_axi_rdata[30:24] == 7'h00)
      else $error("program register unused bits set");
   a_boot_unused: assert property (rb |-> s_axi_rdata[31:16] == 16'h0000 &&
      s_axi_rdata[14:11] == 4'h0 && s_axi_rdata[7:0] == 8'h00)
      else $error("boot register unused bits set");
   a_key_zero: assert property (s_axi_rvalid && rd_ofs_q == FWP_OFS_KEY |-> s_axi_rdata == 32'h0)
      else $error("key register read not zero");
   a_prog_sticky: assert property (rp && plock_q |-> !s_axi_rdata[31])
      else $error("program unlock bit set again");
   a_boot_sticky: assert property (rb && block_q |-> !s_axi_rdata[15])
      else $error("boot unlock bit set again");
   c_refused: cover property (op_refused);
   c_outside: cover property (take && outside);
   c_locked: cover property (rp && plock_q);
endmodule
bind fwp_top fwp_top_chk u_sva (.aclk(aclk), .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
   .op_done(op_done), .op_allowed(op_allowed), .op_refused(op_refused));

/* File: sim/test_flash_write_protect_regs.sv */
`timescale 1ns/1ps
module test_flash_write_protect_regs
   import fwp_pkg::*;
;
   localparam logic [31:0] K1 = 32'h0000a5a5;
   localparam logic [31:0] K2 = 32'h00005a5a;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, op_addr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, op_valid = 1'b0;
   logic [1:0] op_kind = 2'h3, s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, op_done, op_allowed, op_refused;
   int err_count = 0;
   int check_count = 0;
   always #5 aclk = ~aclk;
   fwp_top #(.KEY_FIRST(K1), .KEY_SECOND(K2)) dut (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
      .op_done(op_done), .op_allowed(op_allowed), .op_refused(op_refused));
   // -------------------------------------------------------------
   // Bus and check tasks.
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [1:0] resp(input logic [7:0] a);
      return (a > FWP_OFS_STAT) ? FWP_RESP_SLVERR : FWP_RESP_OKAY;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            got = 1'b1;
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, resp(a));
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            got = 1'b1;
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, exp);
            chk(s_axi_rresp, resp(a));
         end
      end
   endtask
   task automatic unlock;
      wr(FWP_OFS_KEY, K1);
      wr(FWP_OFS_KEY, K2);
   endtask
   task automatic op(input logic [1:0] k, input logic [31:0] a,
         input logic r);
      @(posedge aclk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_addr <= a;
      @(posedge aclk);
      op_valid <= 1'b0;
      @(posedge aclk);
      chk({op_done, op_allowed, op_refused},
         (k == 2'h3) ? 32'h0 : {29'h0, 1'b1, !r, r});
   endtask
   task automatic opall(input logic [31:0] a, input logic r);
      for (int k = 0; k < 3; k++) op(2'(k), a, r);
   endtask
   task automatic boot_pages(input logic [2:0] b);
      logic [31:0] a;
      for (int p = 0; p < 3; p++) begin
         a = 32'h1fc01000 - 32'(p) * 32'h800;
         op(2'h0, a, b[p]);
         op(2'h2, a + 32'h7ff, b[p]);
      end
      op(2'h1, 32'h1fc01800, 1'b0);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // Tests.
   // -------------------------------------------------------------
   initial begin
      #100000;
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(FWP_OFS_PROG, 32'h80000000);
      rd(FWP_OFS_BOOT, 32'h00008700);
      rd(FWP_OFS_KEY, 32'h0);
      rd(8'h10, 32'h0);
      opall(32'h1d000000, 1'b0);
      op(2'h3, 32'h1fc00000, 1'b1);
      boot_pages(3'h7);
      $display("test reset_values done");
      wr(FWP_OFS_PROG, 32'h00001a00);
      rd(FWP_OFS_PROG, 32'h80000000);
      unlock();
      wr(FWP_OFS_PROG, 32'hff001a00);
      rd(FWP_OFS_PROG, 32'h80001a00);
      wr(FWP_OFS_PROG, 32'h80004000);
      rd(FWP_OFS_PROG, 32'h80001a00);
      opall(32'h1d001800, 1'b1);
      opall(32'h1d001fff, 1'b1);
      opall(32'h1d002000, 1'b0);
      opall(32'h1d000000, 1'b1);
      opall(32'h1e000000, 1'b0);
      unlock();
      wr(FWP_OFS_PROG, 32'h00001a00);
      rd(FWP_OFS_PROG, 32'h00001a00);
      unlock();
      wr(FWP_OFS_PROG, 32'h80004000);
      rd(FWP_OFS_PROG, 32'h00001a00);
      $display("test program_boundary done");
      unlock();
      wr(FWP_OFS_BOOT, 32'hffff8500);
      rd(FWP_OFS_BOOT, 32'h00008500);
      boot_pages(3'h5);
      unlock();
      wr(FWP_OFS_BOOT, 32'h00000300);
      rd(FWP_OFS_BOOT, 32'h00000300);
      unlock();
      wr(FWP_OFS_BOOT, 32'h00008400);
      rd(FWP_OFS_BOOT, 32'h00000300);
      boot_pages(3'h3);
      $display("test boot_pages done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(FWP_OFS_PROG, 32'h80000000);
      rd(FWP_OFS_BOOT, 32'h00008700);
      rd(FWP_OFS_STAT, 32'h00000000);
      wr(FWP_OFS_BOOT, 32'h00000000);
      rd(FWP_OFS_BOOT, 32'h00008700);
      op(2'h0, 32'h1fc00000, 1'b1);
      rd(FWP_OFS_STAT, 32'h00000101);
      unlock();
      rd(FWP_OFS_STAT, 32'h00000103);
      wr(FWP_OFS_STAT, 32'h00000001);
      rd(FWP_OFS_STAT, 32'h00000001);
      $display("test second_reset done");
      wrap_up();
   end
endmodule
